// >>> core/amp_regs_map.svh
`ifndef AMP_REGS_MAP_SVH
`define AMP_REGS_MAP_SVH
// register offsets
`define OFS_RIGHT_VOLUME 8'h05
`define OFS_ANALOG_CONTROL 8'h06
`define OFS_RESERVED_SEVEN 8'h07
`define OFS_FAULT_CONFIG_STATUS 8'h08
// reset values
`define RST_RIGHT_VOLUME 8'hCF
`define RST_ANALOG_CONTROL 8'h51
`define RST_FAULT_CONFIG 2'h0
`define RST_SWITCH_RATE 5'h10
`define RST_ANALOG_GAIN 2'h0
// volume codes
`define VOL_MAX_CODE 8'hFF
`define VOL_UNITY_CODE 8'hCF
`define VOL_FLOOR_CODE 8'h07
// analog control fields
`define AC_RATE_HI 6
`define AC_RATE_LO 4
`define AC_GAIN_HI 3
`define AC_GAIN_LO 2
`define AC_CHSEL_BIT 1
// fault register fields
`define FC_THR_HI 5
`define FC_THR_LO 4
`define FC_CLK_BIT 3
`define FC_OC_BIT 2
`define FC_DC_BIT 1
`define FC_OT_BIT 0
`endif

// >>> core/amp_regs_pkg.sv
package amp_regs_pkg;
    typedef enum logic [1:0] {
        GAIN_19P2 = 2'h0,
        GAIN_22P6 = 2'h1,
        GAIN_25 = 2'h2,
        GAIN_RSVD = 2'h3
    } analog_gain_t;
    typedef enum logic [1:0] {
        THR_FULL = 2'h0,
        THR_75 = 2'h1,
        THR_50 = 2'h2,
        THR_25 = 2'h3
    } oc_threshold_t;
    typedef enum logic [1:0] {
        FLT_IDLE = 2'h1,
        FLT_HELD = 2'h2
    } fault_state_t;
endpackage

// >>> core/fault_latch.sv
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs_map.svh"
// sticky fault flag cleared by a shutdown toggle
module fault_latch (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_event,
    input wire logic i_clear,
    output logic o_flag
);
    amp_regs_pkg::fault_state_t state_q;
    amp_regs_pkg::fault_state_t state_d;
    // a new event in the clear cycle keeps the flag set
    always_comb begin
        case (state_q)
            amp_regs_pkg::FLT_IDLE: begin
                state_d = i_event ? amp_regs_pkg::FLT_HELD
                                  : amp_regs_pkg::FLT_IDLE;
            end
            amp_regs_pkg::FLT_HELD: begin
                state_d = (i_clear && !i_event) ? amp_regs_pkg::FLT_IDLE
                                                : amp_regs_pkg::FLT_HELD;
            end
            default: begin
                state_d = amp_regs_pkg::FLT_IDLE;
            end
        endcase
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= amp_regs_pkg::FLT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
    assign o_flag = (state_q == amp_regs_pkg::FLT_HELD);
endmodule
`default_nettype wire

// >>> core/amp_volume_analog_fault_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs_map.svh"
// Notes on behaviour
// [RULE1] 8-bit volume, 0xFF +24 dB, 0.5 dB steps
// [RULE2] code 0xCF is 0 dB, reset value
// [RULE3] code 0x07 is -100 dB
// [RULE4] codes below 0x07 mute the channel
// [RULE5] software writes one to analog bit 7
// [RULE6] bits 6:4 pick switching rate multiple
// [RULE7] double speed halves the switching rate
// [RULE8] bits 3:2 pick analog gain
// [RULE9] software never writes gain code 11
// [RULE10] channel select 0 plays right channel
// [RULE11] channel select 1 plays left channel
// [RULE12] software keeps analog bit 0 at one
// [RULE13] software never accesses offset 0x07
// [RULE14] fault register: threshold 5:4, flags 3:0
// [RULE15] threshold codes: full, 75, 50, 25 percent
// [RULE16] clock fault flag follows clock validity
// [RULE17] other faults latch until shutdown toggles
// [RULE18] speed select one means double speed
// [RULE19] read back last write, flags ignore writes
module amp_volume_analog_fault_regs (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_speed_mode_select,
    input wire logic i_clock_fault,
    input wire logic i_overcurrent_event,
    input wire logic i_dc_offset_event,
    input wire logic i_overtemp_event,
    input wire logic i_amplifier_shutdown_input,
    output logic [7:0] o_reg_rdata,
    output logic [7:0] o_volume_gain_code,
    output logic o_volume_mute,
    output logic [4:0] o_switch_rate_mult,
    output logic [1:0] o_analog_gain,
    output logic o_use_left_channel,
    output logic [1:0] o_overcurrent_threshold_select,
    output logic o_amp_faulted
);
    // software-visible storage
    logic [7:0] right_volume_q;
    logic [7:0] analog_control_q;
    logic [1:0] fault_config_q;
    // status sampling
    logic clock_fault_flag_q;
    logic shutdown_q;
    // registered outputs
    logic [7:0] rdata_q;
    logic [7:0] vol_code_q;
    logic mute_q;
    logic [4:0] rate_q;
    logic [1:0] gain_q;
    logic left_q;
    logic faulted_q;
    // outputs of the sticky latches
    logic overcurrent_flag;
    logic dc_offset_flag;
    logic overtemp_flag;

    // multiple of the frame clock for each rate code
    function automatic logic [4:0] rate_mult(input logic [2:0] code);
        case (code)
            3'h0: rate_mult = 5'h06;
            3'h1: rate_mult = 5'h08;
            3'h2: rate_mult = 5'h0A;
            3'h3: rate_mult = 5'h0C;
            3'h4: rate_mult = 5'h0E;
            3'h5: rate_mult = 5'h10;
            3'h6: rate_mult = 5'h14;
            default: rate_mult = 5'h18;
        endcase
    endfunction

    // one offset compare shared by the write decode and the read mux
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    // register select, used by writes and reads alike
    wire sel_vol = addr_hit(i_reg_addr, `OFS_RIGHT_VOLUME);
    wire sel_ac = addr_hit(i_reg_addr, `OFS_ANALOG_CONTROL);
    wire sel_fc = addr_hit(i_reg_addr, `OFS_FAULT_CONFIG_STATUS);
    // address decode; other offsets take no write
    wire wr_vol = i_reg_wr && sel_vol;
    wire wr_ac = i_reg_wr && sel_ac;
    wire wr_fc = i_reg_wr && sel_fc;
    // toggle of the shutdown input clears latched faults
    // either edge counts, so the controller may park at any level
    // [RULE17] shutdown toggle clears
    wire shutdown_toggle = i_amplifier_shutdown_input != shutdown_q;
    // bits 7:6 are reserved and always read zero
    // [RULE14] fault register layout
    wire [7:0] fault_view = {2'h0, fault_config_q, clock_fault_flag_q,
                             overcurrent_flag, dc_offset_flag,
                             overtemp_flag};
    // read mux; reserved and unmapped offsets read zero
    // a write in the same cycle is not seen: the old value is read
    // [RULE19] read back
    wire [7:0] rd_mux =
        sel_vol ? right_volume_q :
        sel_ac ? analog_control_q :
        sel_fc ? fault_view : 8'h00;
    // the floor code itself stays audible, only lower codes mute
    // [RULE4] mute below floor
    wire vol_mute = right_volume_q < `VOL_FLOOR_CODE;
    // [RULE6] rate decode
    wire [4:0] rate_full = rate_mult(
        analog_control_q[`AC_RATE_HI:`AC_RATE_LO]);
    // every multiple is even, so halving drops no fraction
    // [RULE7] halve at double speed
    // [RULE18] speed select high
    wire [4:0] rate_eff = i_speed_mode_select ? {1'b0, rate_full[4:1]}
                                              : rate_full;

    // writable registers
    // bit 7 of analog control is plain storage that software sets
    // gain code 11 is kept as written; software must avoid it
    // [RULE2] reset to unity
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            right_volume_q <= `RST_RIGHT_VOLUME;
            analog_control_q <= `RST_ANALOG_CONTROL;
            fault_config_q <= `RST_FAULT_CONFIG;
        end else begin
            if (wr_vol) begin
                right_volume_q <= i_reg_wdata;
            end
            if (wr_ac) begin
                analog_control_q <= i_reg_wdata;
            end
            // only the threshold bits are stored here
            // [RULE19] flags ignore writes
            if (wr_fc) begin
                fault_config_q <= i_reg_wdata[`FC_THR_HI:`FC_THR_LO];
            end
        end
    end

    // status tracking and registered outputs
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            clock_fault_flag_q <= 1'b0;
            shutdown_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            // the clock flag is a plain copy, it clears once clocks recover
            // [RULE16] non-latching clock flag
            clock_fault_flag_q <= i_clock_fault;
            shutdown_q <= i_amplifier_shutdown_input;
            // read data holds until the next read strobe
            if (i_reg_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // drive the amplifier controls
    // outputs start at the register reset values, so the amp wakes at unity
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            vol_code_q <= `RST_RIGHT_VOLUME;
            mute_q <= 1'b0;
            rate_q <= `RST_SWITCH_RATE;
            gain_q <= `RST_ANALOG_GAIN;
            left_q <= 1'b0;
            faulted_q <= 1'b0;
        end else begin
            // [RULE1] gain code passes on
            // [RULE3] floor code still audible
            vol_code_q <= right_volume_q;
            mute_q <= vol_mute;
            rate_q <= rate_eff;
            // [RULE8] analog gain field
            gain_q <= analog_control_q[`AC_GAIN_HI:`AC_GAIN_LO];
            // [RULE10] [RULE11] channel select
            left_q <= analog_control_q[`AC_CHSEL_BIT];
            // any flag, latched or not, holds the amplifier off
            faulted_q <= clock_fault_flag_q | overcurrent_flag |
                         dc_offset_flag | overtemp_flag;
        end
    end

    // [RULE17] latched fault flags
    // one sticky latch per protection event, all cleared by one toggle
    wire [2:0] fault_events = {i_overcurrent_event, i_dc_offset_event,
                               i_overtemp_event};
    wire [2:0] latched_flags;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_latch
            fault_latch u_fault_latch (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_event(fault_events[g]),
                .i_clear(shutdown_toggle),
                .o_flag(latched_flags[g])
            );
        end
    endgenerate
    // bit order follows the status field layout
    assign overcurrent_flag = latched_flags[2];
    assign dc_offset_flag = latched_flags[1];
    assign overtemp_flag = latched_flags[0];

    assign o_reg_rdata = rdata_q;
    assign o_volume_gain_code = vol_code_q;
    assign o_volume_mute = mute_q;
    assign o_switch_rate_mult = rate_q;
    assign o_analog_gain = gain_q;
    assign o_use_left_channel = left_q;
    // [RULE15] threshold code to protection
    assign o_overcurrent_threshold_select = fault_config_q;
    assign o_amp_faulted = faulted_q;
endmodule
`default_nettype wire

// >>> tb/amp_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches the register port and the derived outputs
module amp_regs_monitor (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_speed_mode_select,
    input wire logic i_clock_fault,
    input wire logic i_overcurrent_event,
    input wire logic i_dc_offset_event,
    input wire logic i_overtemp_event,
    input wire logic i_amplifier_shutdown_input,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [7:0] o_volume_gain_code,
    input wire logic o_volume_mute,
    input wire logic [4:0] o_switch_rate_mult,
    input wire logic [1:0] o_analog_gain,
    input wire logic o_use_left_channel,
    input wire logic [1:0] o_overcurrent_threshold_select,
    input wire logic o_amp_faulted
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [4:0] rt [8] = '{5'h06, 5'h08, 5'h0A, 5'h0C,
                           5'h0E, 5'h10, 5'h14, 5'h18};
    // write decodes per register
    wire logic wr_vol = i_reg_wr && (i_reg_addr == 8'h05);
    wire logic wr_ac = i_reg_wr && (i_reg_addr == 8'h06);
    wire logic wr_flt = i_reg_wr && (i_reg_addr == 8'h08);
    // derived outputs other than the threshold select lag the register by one edge
    vol_write_a: assert property (
        wr_vol |-> ##2 o_volume_gain_code == $past(i_reg_wdata, 2))
        else $error("volume code wrong");
    mute_floor_a: assert property (
        o_volume_mute == (o_volume_gain_code < 8'h07)) else $error("mute wrong");
    rate_mult_a: assert property (
        wr_ac ##1 $stable(i_speed_mode_select) [*2] |-> o_switch_rate_mult
        == (rt[$past(i_reg_wdata[6:4], 2)] >> i_speed_mode_select))
        else $error("rate wrong");
    gain_write_a: assert property (
        wr_ac |=> ##1 o_analog_gain == $past(i_reg_wdata[3:2], 2))
        else $error("gain wrong");
    chan_write_a: assert property (
        wr_ac |-> ##2 o_use_left_channel == $past(i_reg_wdata[1], 2))
        else $error("channel wrong");
    thr_write_a: assert property (
        wr_flt |=> o_overcurrent_threshold_select == $past(i_reg_wdata[5:4]))
        else $error("threshold wrong");
    rsvd_bits_a: assert property (
        i_reg_rd && i_reg_addr == 8'h08 |=> o_reg_rdata[7:6] == 2'h0)
        else $error("reserved bits wrong");
    rdata_hold_a: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
    clk_fault_a: assert property (
        i_clock_fault |-> ##2 o_amp_faulted) else $error("clock fault missed");
    oc_latch_a: assert property (
        i_overcurrent_event |=> ##1 o_amp_faulted) else $error("fault missed");
endmodule
bind amp_volume_analog_fault_regs amp_regs_monitor u_amp_regs_monitor (.*);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_speed_mode_select = 1'b0;
    logic i_clock_fault = 1'b0, i_amplifier_shutdown_input = 1'b0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, v;
    logic [2:0] ev = 3'h0;
    logic [7:0] o_reg_rdata, o_volume_gain_code;
    logic o_volume_mute, o_use_left_channel, o_amp_faulted;
    logic [4:0] o_switch_rate_mult;
    logic [1:0] o_analog_gain, o_overcurrent_threshold_select;
    logic [31:0] seed = 32'h3F1E;
    logic [7:0] want;
    logic [7:0] corner [4] = '{8'h07, 8'h06, 8'h00, 8'hFF};
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    amp_volume_analog_fault_regs u_amp_volume_analog_fault_regs (
        .i_overcurrent_event(ev[2]),
        .i_dc_offset_event(ev[1]),
        .i_overtemp_event(ev[0]),
        .*
    );
    // clock source
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    // hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // switching multiple for a rate code, halved at double speed
    function automatic logic [7:0] exp_rate(input logic [2:0] code,
                                            input logic ds);
        logic [7:0] m;
        case (code)
            3'h0: m = 8'h06;
            3'h1: m = 8'h08;
            3'h2: m = 8'h0A;
            3'h3: m = 8'h0C;
            3'h4: m = 8'h0E;
            3'h5: m = 8'h10;
            3'h6: m = 8'h14;
            default: m = 8'h18;
        endcase
        return ds ? (m >> 1) : m;
    endfunction
    // codes below the audible floor mute the channel
    function automatic logic [7:0] exp_mute(input logic [7:0] code);
        return (code < 8'h07) ? 8'h01 : 8'h00;
    endfunction
    task automatic chk(input logic [7:0] seen, exp, input string n);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1 chk(o_reg_rdata, e, "rdata");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1 chk(8'(o_switch_rate_mult), 8'h10, "rate");
        chk(8'(o_use_left_channel), 8'h00, "left");
        chk(8'(o_overcurrent_threshold_select), 8'h00, "thr");
        rd(8'h05, 8'hCF);
        rd(8'h06, 8'h51);
        rd(8'h08, 8'h00);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            v = (i < 4) ? corner[i] : seed[7:0];
            wr(8'h05, v);
            chk(o_volume_gain_code, v, "volume");
            chk(8'(o_volume_mute), exp_mute(v), "mute");
            rd(8'h05, v);
        end
        for (int i = 0; i < 16; i++) begin
            // bits 7 and 0 written as one
            // gain code cycles through 0 to 2, never 11
            v = {1'b1, 3'(i), 2'(i % 3), i[1], 1'b1};
            i_speed_mode_select <= i[3];
            wr(8'h06, v);
            want = exp_rate(3'(i), i[3]);
            chk(8'(o_switch_rate_mult), want, "rate");
            chk(8'(o_analog_gain), 8'(i % 3), "gain");
            chk(8'(o_use_left_channel), 8'(i[1]), "left");
            rd(8'h06, v);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, {2'h3, 2'(i), 4'hF});
            chk(8'(o_overcurrent_threshold_select), 8'(i), "thr");
            rd(8'h08, 8'(i * 16));
        end
        i_clock_fault <= 1'b1;
        rd(8'h08, 8'h38);
        chk(8'(o_amp_faulted), 8'h01, "fault");
        i_clock_fault <= 1'b0;
        rd(8'h08, 8'h30);
        rd(8'h08, 8'h30);
        chk(8'(o_amp_faulted), 8'h00, "fault");
        for (int b = 0; b < 3; b++) begin
            ev <= 3'(1 << b);
            @(posedge i_clk);
            ev <= 3'h0;
            rd(8'h08, 8'h30 | 8'(1 << b));
            rd(8'h08, 8'h30 | 8'(1 << b));
            chk(8'(o_amp_faulted), 8'h01, "fault");
            i_amplifier_shutdown_input <= ~i_amplifier_shutdown_input;
            rd(8'h08, 8'h30);
            rd(8'h08, 8'h30);
            chk(8'(o_amp_faulted), 8'h00, "fault");
        end
        stop_test();
    end
endmodule
`default_nettype wire
